// ### pmc_mic_link.sv
// Bit clock generator and data pin sampler for the mic port.
// Assumes the data pin is asynchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
module pmc_mic_link (
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  input  wire logic       run,        // Clock toggles while high
  input  wire logic [7:0] half_div,   // System cycles per half period
  input  wire logic       din_pin,    // Shared microphone data
  output logic            mic_clk,    // Bit clock level
  output logic            fall_bit,   // Bit taken at falling edge
  output logic            rise_bit,   // Bit taken at rising edge
  output logic            bit_done    // Pulse: one clock period over
);
  // All state of the link
  typedef struct packed {
    logic [7:0] cnt;
    logic       clk;
    logic       s1;
    logic       s2;
    logic       s3;
    logic       din;
    logic       fbit;
    logic       rbit;
    logic       done;
  } pmc_link_t;

  pmc_link_t r_reg;
  pmc_link_t r_next;

  // Divider, three-stage sync and edge sampling
  always_comb begin
    r_next      = r_reg;
    r_next.done = 1'b0;
    r_next.s1   = din_pin;
    r_next.s2   = r_reg.s1;
    r_next.s3   = r_reg.s2;
    // Accept a change only once two late stages agree
    if (r_reg.s2 == r_reg.s3) begin
      r_next.din = r_reg.s3;
    end
    if (!run) begin
      // Idle: clock parked low
      r_next.cnt = 8'h00;
      r_next.clk = 1'b0;
    end else if (r_reg.cnt >= half_div - 8'h01) begin
      r_next.cnt = 8'h00;
      r_next.clk = ~r_reg.clk;
      if (r_reg.clk) begin
        // Falling edge now, period closes with both bits fresh
        r_next.fbit = r_reg.din;
        r_next.done = 1'b1;
      end else begin
        // Rising edge now, first half of the period
        r_next.rbit = r_reg.din;
      end
    end else begin
      r_next.cnt = r_reg.cnt + 8'h01;
    end
    if (!rst_n) begin
      r_next = '0;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    r_reg <= r_next;
  end

  assign mic_clk  = r_reg.clk;
  assign fall_bit = r_reg.fbit;
  assign rise_bit = r_reg.rbit;
  assign bit_done = r_reg.done;
endmodule // pmc_mic_link
`default_nettype wire

// ### pmc_mic_model.sv
// Behavioural pair of digital mics on one shared data line.
// Assumes the port's bit clock and its pin routing flags.
`timescale 1ns/1ps
`default_nettype none
module pmc_mic_model (
  input  wire logic clk_sys,  // System clock, for the float pattern
  input  wire logic mic_clk,  // Bit clock from the port
  input  wire logic clk_on,   // Clock reaches the pin
  input  wire logic din_on,   // Data pin is listened to
  output logic      din       // Shared data line
);
  logic wob = 1'b0;           // Floating line pattern
  // Unrouted line changes every cycle
  always @(posedge clk_sys) begin
    wob <= ~wob;
  end
  // left mic drives ones, right mic zeros
  assign din = (clk_on & din_on) ? mic_clk : wob;
endmodule // pmc_mic_model
`default_nettype wire

// ### pmc_pkg.sv
// Constants, offsets, field positions and types for the mic port.
// Assumes a 200 MHz system clock and a word-aligned register port.
`default_nettype none
package pmc_pkg;
  // Register offsets
  localparam logic [11:0] A_START       = 12'h000;
  localparam logic [11:0] A_STOP        = 12'h004;
  localparam logic [11:0] A_SUB_START   = 12'h080;
  localparam logic [11:0] A_SUB_STOP    = 12'h084;
  localparam logic [11:0] A_EV_STARTED  = 12'h100;
  localparam logic [11:0] A_EV_STOPPED  = 12'h104;
  localparam logic [11:0] A_EV_END      = 12'h108;
  localparam logic [11:0] A_PUB_STARTED = 12'h180;
  localparam logic [11:0] A_PUB_STOPPED = 12'h184;
  localparam logic [11:0] A_PUB_END     = 12'h188;
  localparam logic [11:0] A_INTERRUPT_MASK       = 12'h300;
  localparam logic [11:0] A_INTERRUPT_MASK_SET    = 12'h304;
  localparam logic [11:0] A_INTERRUPT_MASK_CLEAR    = 12'h308;
  localparam logic [11:0] A_ENABLE      = 12'h500;
  localparam logic [11:0] A_CLKCTRL     = 12'h504;
  localparam logic [11:0] A_MODE        = 12'h508;
  localparam logic [11:0] A_GAIN_L      = 12'h518;
  localparam logic [11:0] A_GAIN_R      = 12'h51C;
  localparam logic [11:0] A_RATIO       = 12'h520;
  localparam logic [11:0] A_PSEL_CLK    = 12'h540;
  localparam logic [11:0] A_PSEL_DIN    = 12'h544;
  localparam logic [11:0] A_PTR         = 12'h560;
  localparam logic [11:0] A_MAXCNT      = 12'h564;
  // Field positions
  localparam int CFG_EN_BIT  = 31;  // Subscribe/publish enable
  localparam int CONNECT_BIT = 31;  // Pin select disconnect
  localparam int OP_MONO_BIT = 0;   // Channel routing: mono
  localparam int EDGE_BIT    = 1;   // Channel routing: edge swap
  localparam int EV_STARTED  = 0;   // Event and mask bit order
  localparam int EV_STOPPED  = 1;
  localparam int EV_END      = 2;
  // Reset values
  localparam logic [31:0] CLKCTRL_RST = 32'h0840_0000;
  localparam logic [6:0]  GAIN_RST    = 7'h28;
  localparam logic [31:0] PSEL_RST    = 32'hFFFF_FFFF;
  // Bit clock periods per sample
  localparam logic [6:0]  RATIO_64    = 7'h40;
  localparam logic [6:0]  RATIO_80    = 7'h50;
  // Timing: system clock and bit clock rates
  localparam int SYS_KHZ     = 200000;
  localparam int MIC_KHZ_DEF = 1032;
  localparam logic [7:0] HALF_DEF = 8'((SYS_KHZ / MIC_KHZ_DEF) / 2);
  // Sequencer states
  typedef enum logic [1:0] {
    PMC_IDLE  = 2'b00,
    PMC_RUN   = 2'b01,
    PMC_DRAIN = 2'b10,
    PMC_ACK   = 2'b11
  } pmc_fsm_t;
endpackage
`default_nettype wire

// ### pmc_top.sv
// Register bank, capture sequencer and sample writer of the mic port.
// Assumes a one-cycle register port and a RAM writer that never stalls.
`timescale 1ns/1ps
`default_nettype none
// How it works
// R1 - Mono mic: only its wired channel valid
// R2 - Disconnected pin select routes no signal
// R3 - Pin selects apply only while enabled
// R4 - Pin selects lost when system powers off
// R5 - Software presets clock low, data input
// R6 - Each pin serves one peripheral only
// R7 - Start write begins capture and writing
// R8 - Stop write requests capture end
// R9 - Subscribed channel event triggers task
// R10 - Events published onto selected channel
// R11 - Started flag set on start, writable
// R12 - Stopped flag set when all finished
// R13 - End flag on full buffer or stop
// R14 - Mask holds started, stopped, end bits
// R15 - Mask set: ones enable, zeros ignored
// R16 - Clock control resets to default rate
// R17 - Ratio picks clock periods per sample
// R18 - Pointer and count define RAM buffer
// R19 - Routing selects mono and edge choice
// R20 - Left on falling edge unless swapped
// R21 - Stop waits for current frame write
// R22 - Pointer double-buffered, swap without gap
// R23 - Word packs right high, left low
// R24 - Mask clear: ones disable, zeros ignored
// R25 - Flag write clears; masked flags interrupt
module pmc_top (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  input  wire logic [11:0] reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_we,
  input  wire logic        reg_re,
  output logic      [31:0] reg_rdata,
  input  wire logic [15:0] chan_in,     // Interconnect channel pulses
  output logic      [15:0] chan_out,    // Published event pulses
  output logic             irq,
  input  wire logic        din_pin,     // Microphone data pin
  output logic             mic_bit_clock,
  output logic             mic_clk_oe,
  output logic             clk_route,   // Clock signal on its pin
  output logic       [4:0] clk_pin,
  output logic             din_route,   // Data signal from its pin
  output logic       [4:0] din_pin_num,
  output logic      [31:0] dma_addr,
  output logic      [31:0] dma_wdata,
  output logic             dma_we
);
  // All state of the block
  typedef struct packed {
    pmc_pkg::pmc_fsm_t fsm;
    logic [4:0][4:0] cfg;      // {en,index}: sub x2, pub x3
    logic [2:0]  ev;
    logic [2:0]  interrupt_mask;
    logic        enable;
    logic [31:0] clkctrl;
    logic [1:0]  mode;
    logic [6:0]  gain_l;
    logic [6:0]  gain_r;
    logic        ratio;
    logic [31:0] psel_clk;
    logic [31:0] psel_din;
    logic [31:0] ptr_sh;       // Software-written pointer
    logic [31:0] ptr_act;      // Pointer in use
    logic [15:0] maxcnt;
    logic [15:0] wcnt;         // Samples written this buffer
    logic [6:0]  per;
    logic [6:0]  ones_l;
    logic [6:0]  ones_r;
    logic [15:0] half;         // Earlier mono sample
    logic        half_v;
    logic [31:0] rdata;
    logic [31:0] daddr;
    logic [31:0] dwdata;
    logic        dwe;
    logic        irq;
    logic [15:0] chan_out;
    logic        croute;
    logic        droute;
  } pmc_state_t;

  pmc_state_t r_reg;
  pmc_state_t r_next;

  logic       mic_clk;
  logic       fall_bit;
  logic       rise_bit;
  logic       bit_done;
  logic       start_t;
  logic       stop_t;
  logic [2:0] ev_p;        // Event pulses this cycle
  logic [2:0] ev_clr;      // Flags written by software
  logic [7:0] half_div;

  // Bit clock half period from the rate field
  always_comb begin
    case (r_reg.clkctrl[31:20])
      12'h080: half_div = 8'd100;
      12'h088: half_div = 8'd94;
      12'h098: half_div = 8'd81;
      12'h0A0: half_div = 8'd78;
      12'h0A8: half_div = 8'd75;
      default: half_div = pmc_pkg::HALF_DEF;
    endcase
  end

  // Bit clock and data sampling
  pmc_mic_link u_link (
    .clk_sys  (clk_sys),
    .rst_n    (rst_n),
    .run      (r_reg.fsm != pmc_pkg::PMC_IDLE),
    .half_div (half_div),
    .din_pin  (din_pin),
    .mic_clk  (mic_clk),
    .fall_bit (fall_bit),
    .rise_bit (rise_bit),
    .bit_done (bit_done)
  );

  // Whole next-state function
  always_comb begin
    logic        lb;
    logic        rb;
    logic [6:0]  nper;
    logic [6:0]  nl;
    logic [6:0]  nr;
    logic [7:0]  dl;
    logic [7:0]  dr;
    logic        wr;
    logic [31:0] word;
    lb   = 1'b0;
    rb   = 1'b0;
    nper = 7'h00;
    nl   = 7'h00;
    nr   = 7'h00;
    dl   = 8'h00;
    dr   = 8'h00;
    wr   = 1'b0;
    word = 32'h0000_0000;
    r_next          = r_reg;
    r_next.dwe      = 1'b0;
    r_next.chan_out = 16'h0000;
    ev_p            = 3'b000;
    ev_clr          = 3'b000;
    // R7 R9 start by write or subscription
    start_t = (reg_we && reg_addr == pmc_pkg::A_START && reg_wdata[0])
           || (r_reg.cfg[0][4] && chan_in[r_reg.cfg[0][3:0]]);
    // R8 R9 stop by write or subscription
    stop_t  = (reg_we && reg_addr == pmc_pkg::A_STOP && reg_wdata[0])
           || (r_reg.cfg[1][4] && chan_in[r_reg.cfg[1][3:0]]);
    // Register writes
    if (reg_we) begin
      case (reg_addr)
        pmc_pkg::A_SUB_START:   r_next.cfg[0] = {reg_wdata[31], reg_wdata[3:0]};
        pmc_pkg::A_SUB_STOP:    r_next.cfg[1] = {reg_wdata[31], reg_wdata[3:0]};
        pmc_pkg::A_PUB_STARTED: r_next.cfg[2] = {reg_wdata[31], reg_wdata[3:0]};
        pmc_pkg::A_PUB_STOPPED: r_next.cfg[3] = {reg_wdata[31], reg_wdata[3:0]};
        pmc_pkg::A_PUB_END:     r_next.cfg[4] = {reg_wdata[31], reg_wdata[3:0]};
        // R25 any write clears a flag
        pmc_pkg::A_EV_STARTED:  ev_clr[pmc_pkg::EV_STARTED] = 1'b1;
        pmc_pkg::A_EV_STOPPED:  ev_clr[pmc_pkg::EV_STOPPED] = 1'b1;
        pmc_pkg::A_EV_END:      ev_clr[pmc_pkg::EV_END] = 1'b1;
        // R14 direct mask
        pmc_pkg::A_INTERRUPT_MASK:       r_next.interrupt_mask = reg_wdata[2:0];
        // R15 set ones only
        pmc_pkg::A_INTERRUPT_MASK_SET:    r_next.interrupt_mask = r_reg.interrupt_mask | reg_wdata[2:0];
        // R24 clear ones only
        pmc_pkg::A_INTERRUPT_MASK_CLEAR:    r_next.interrupt_mask = r_reg.interrupt_mask & ~reg_wdata[2:0];
        pmc_pkg::A_ENABLE:      r_next.enable = reg_wdata[0];
        pmc_pkg::A_CLKCTRL:     r_next.clkctrl = reg_wdata;
        // R19 mono and edge fields
        pmc_pkg::A_MODE:        r_next.mode = reg_wdata[1:0];
        pmc_pkg::A_GAIN_L:      r_next.gain_l = reg_wdata[6:0];
        pmc_pkg::A_GAIN_R:      r_next.gain_r = reg_wdata[6:0];
        pmc_pkg::A_RATIO:       r_next.ratio = reg_wdata[0];
        pmc_pkg::A_PSEL_CLK:    r_next.psel_clk = reg_wdata;
        pmc_pkg::A_PSEL_DIN:    r_next.psel_din = reg_wdata;
        pmc_pkg::A_PTR:         r_next.ptr_sh = reg_wdata;
        pmc_pkg::A_MAXCNT:      r_next.maxcnt = reg_wdata[15:0];
        default: ;
      endcase
    end
    // Read data, zero for unmapped or write-only
    r_next.rdata = 32'h0000_0000;
    if (reg_re) begin
      case (reg_addr)
        pmc_pkg::A_SUB_START:   r_next.rdata = {r_reg.cfg[0][4], 27'h0, r_reg.cfg[0][3:0]};
        pmc_pkg::A_SUB_STOP:    r_next.rdata = {r_reg.cfg[1][4], 27'h0, r_reg.cfg[1][3:0]};
        pmc_pkg::A_PUB_STARTED: r_next.rdata = {r_reg.cfg[2][4], 27'h0, r_reg.cfg[2][3:0]};
        pmc_pkg::A_PUB_STOPPED: r_next.rdata = {r_reg.cfg[3][4], 27'h0, r_reg.cfg[3][3:0]};
        pmc_pkg::A_PUB_END:     r_next.rdata = {r_reg.cfg[4][4], 27'h0, r_reg.cfg[4][3:0]};
        pmc_pkg::A_EV_STARTED:  r_next.rdata = {31'h0, r_reg.ev[0]};
        pmc_pkg::A_EV_STOPPED:  r_next.rdata = {31'h0, r_reg.ev[1]};
        pmc_pkg::A_EV_END:      r_next.rdata = {31'h0, r_reg.ev[2]};
        pmc_pkg::A_INTERRUPT_MASK, pmc_pkg::A_INTERRUPT_MASK_SET, pmc_pkg::A_INTERRUPT_MASK_CLEAR:
          r_next.rdata = {29'h0, r_reg.interrupt_mask};
        pmc_pkg::A_ENABLE:      r_next.rdata = {31'h0, r_reg.enable};
        pmc_pkg::A_CLKCTRL:     r_next.rdata = r_reg.clkctrl;
        pmc_pkg::A_MODE:        r_next.rdata = {30'h0, r_reg.mode};
        pmc_pkg::A_GAIN_L:      r_next.rdata = {25'h0, r_reg.gain_l};
        pmc_pkg::A_GAIN_R:      r_next.rdata = {25'h0, r_reg.gain_r};
        pmc_pkg::A_RATIO:       r_next.rdata = {31'h0, r_reg.ratio};
        pmc_pkg::A_PSEL_CLK:    r_next.rdata = r_reg.psel_clk;
        pmc_pkg::A_PSEL_DIN:    r_next.rdata = r_reg.psel_din;
        pmc_pkg::A_PTR:         r_next.rdata = r_reg.ptr_sh;
        pmc_pkg::A_MAXCNT:      r_next.rdata = {16'h0, r_reg.maxcnt};
        default:                r_next.rdata = 32'h0000_0000;
      endcase
    end
    // R1 R20 edge to channel, swap on edge field
    lb = r_reg.mode[pmc_pkg::EDGE_BIT] ? rise_bit : fall_bit;
    rb = r_reg.mode[pmc_pkg::EDGE_BIT] ? fall_bit : rise_bit;
    // Sequencer
    case (r_reg.fsm)
      pmc_pkg::PMC_IDLE: begin
        if (start_t && r_reg.enable) begin
          // R7 R11 start capture
          r_next.fsm     = pmc_pkg::PMC_RUN;
          r_next.ptr_act = r_reg.ptr_sh;
          r_next.wcnt    = 16'h0000;
          r_next.per     = 7'h00;
          r_next.ones_l  = 7'h00;
          r_next.ones_r  = 7'h00;
          r_next.half_v  = 1'b0;
          ev_p[pmc_pkg::EV_STARTED] = 1'b1;
        end else if (stop_t) begin
          ev_p[pmc_pkg::EV_STOPPED] = 1'b1;
        end
      end
      pmc_pkg::PMC_RUN, pmc_pkg::PMC_DRAIN: begin
        // R8 R21 stop waits for the frame
        if (stop_t) begin
          r_next.fsm = pmc_pkg::PMC_DRAIN;
        end
        if (bit_done) begin
          // R17 periods per sample from ratio
          nl   = r_reg.ones_l + {6'h00, lb};
          nr   = r_reg.ones_r + {6'h00, rb};
          nper = r_reg.per + 7'h01;
          r_next.per    = nper;
          r_next.ones_l = nl;
          r_next.ones_r = nr;
          if (nper == (r_reg.ratio ? pmc_pkg::RATIO_80
                                   : pmc_pkg::RATIO_64)) begin
            // Density to signed PCM
            dl = {nl, 1'b0} - {1'b0, nper};
            dr = {nr, 1'b0} - {1'b0, nper};
            r_next.per    = 7'h00;
            r_next.ones_l = 7'h00;
            r_next.ones_r = 7'h00;
            if (!r_reg.mode[pmc_pkg::OP_MONO_BIT]) begin
              // R23 right high, left low
              word = {dr, 8'h00, dl, 8'h00};
              wr   = 1'b1;
            end else if (!r_reg.half_v) begin
              r_next.half   = {dl, 8'h00};
              r_next.half_v = 1'b1;
            end else begin
              // R23 earlier mono sample low
              word = {dl, 8'h00, r_reg.half};
              wr   = 1'b1;
              r_next.half_v = 1'b0;
            end
          end
        end
        if (wr) begin
          // R18 word address from pointer and count
          r_next.dwe    = 1'b1;
          r_next.dwdata = word;
          r_next.daddr  = r_reg.ptr_act + {15'h0000, r_reg.wcnt, 1'b0};
          r_next.wcnt   = r_reg.wcnt + 16'h0002;
          if (r_reg.fsm == pmc_pkg::PMC_DRAIN || stop_t) begin
            // R13 last sample after stop
            ev_p[pmc_pkg::EV_END] = 1'b1;
            r_next.fsm = pmc_pkg::PMC_ACK;
          end else if (r_reg.wcnt + 16'h0002 >= r_reg.maxcnt) begin
            // R13 R22 full buffer, swap pointer, restart
            ev_p[pmc_pkg::EV_END]     = 1'b1;
            ev_p[pmc_pkg::EV_STARTED] = 1'b1;
            r_next.ptr_act = r_reg.ptr_sh;
            r_next.wcnt    = 16'h0000;
          end
        end
        if (!r_reg.enable) begin
          r_next.fsm = pmc_pkg::PMC_IDLE;
        end
      end
      pmc_pkg::PMC_ACK: begin
        // R12 R21 all writes done
        ev_p[pmc_pkg::EV_STOPPED] = 1'b1;
        r_next.fsm = pmc_pkg::PMC_IDLE;
      end
      default: r_next.fsm = pmc_pkg::PMC_IDLE;
    endcase
    // R11 R25 set wins over clear
    r_next.ev = (r_reg.ev & ~ev_clr) | ev_p;
    // R10 publish each event
    for (int k = 0; k < 3; k++) begin
      if (ev_p[k] && r_reg.cfg[2 + k][4]) begin
        r_next.chan_out[r_reg.cfg[2 + k][3:0]] = 1'b1;
      end
    end
    // R25 masked flags raise interrupt
    r_next.irq    = |(r_next.ev & r_next.interrupt_mask);
    // R2 R3 route only enabled and connected
    r_next.croute = r_next.enable && !r_next.psel_clk[pmc_pkg::CONNECT_BIT];
    r_next.droute = r_next.enable && !r_next.psel_din[pmc_pkg::CONNECT_BIT];
    if (!rst_n) begin
      // R4 R16 everything back to defaults
      r_next          = '0;
      r_next.fsm      = pmc_pkg::PMC_IDLE;
      r_next.clkctrl  = pmc_pkg::CLKCTRL_RST;
      r_next.gain_l   = pmc_pkg::GAIN_RST;
      r_next.gain_r   = pmc_pkg::GAIN_RST;
      r_next.psel_clk = pmc_pkg::PSEL_RST;
      r_next.psel_din = pmc_pkg::PSEL_RST;
    end
  end

  // State register
  always_ff @(posedge clk_sys) begin
    r_reg <= r_next;
  end

  assign reg_rdata     = r_reg.rdata;
  assign chan_out      = r_reg.chan_out;
  assign irq           = r_reg.irq;
  assign mic_bit_clock = mic_clk;
  assign mic_clk_oe    = r_reg.croute;
  assign clk_route     = r_reg.croute;
  assign clk_pin       = r_reg.psel_clk[4:0];
  assign din_route     = r_reg.droute;
  assign din_pin_num   = r_reg.psel_din[4:0];
  assign dma_addr      = r_reg.daddr;
  assign dma_wdata     = r_reg.dwdata;
  assign dma_we        = r_reg.dwe;

  // Bit period that may close a sample this cycle
  logic wr_any;
  assign wr_any = bit_done && r_reg.per != 7'h00;

  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_start_flag: assert property ( // R7
    r_reg.fsm == pmc_pkg::PMC_IDLE && start_t && r_reg.enable
    |=> r_reg.ev[0] && r_reg.fsm == pmc_pkg::PMC_RUN)
    else $error("start did not raise started flag");
  a_stop_drain: assert property ( // R8
    r_reg.fsm == pmc_pkg::PMC_RUN && stop_t && !wr_any && r_reg.enable
    |=> r_reg.fsm == pmc_pkg::PMC_DRAIN)
    else $error("stop did not enter drain");
  a_stopped_ack: assert property ( // R12
    r_reg.fsm == pmc_pkg::PMC_ACK |=> r_reg.ev[1] ##1 1'b1)
    else $error("stopped flag missing after drain");
  a_route_off: assert property ( // R3
    !r_reg.enable |-> !clk_route && !din_route && !mic_clk_oe)
    else $error("pins routed while disabled");
  a_mask_set: assert property ( // R15
    reg_we && reg_addr == pmc_pkg::A_INTERRUPT_MASK_SET && reg_wdata[0]
    |=> r_reg.interrupt_mask[0])
    else $error("mask set ignored");
  a_mask_clr: assert property ( // R24
    reg_we && reg_addr == pmc_pkg::A_INTERRUPT_MASK_CLEAR && reg_wdata[1]
    |=> !r_reg.interrupt_mask[1])
    else $error("mask clear ignored");
  a_ptr_swap: assert property ( // R22
    ev_p[2] && ev_p[0] |=> r_reg.ptr_act == $past(r_reg.ptr_sh)
    && r_reg.wcnt == 16'h0000)
    else $error("pointer not swapped at buffer end");
  a_irq_level: assert property ( // R25
    (r_reg.ev & r_reg.interrupt_mask) == 3'b000 ##1 (r_reg.ev & r_reg.interrupt_mask)
    == 3'b000 |-> !irq)
    else $error("interrupt without masked flag");
  a_pub_pulse: assert property ( // R10
    ev_p[1] && r_reg.cfg[3][4] |=> chan_out[$past(r_reg.cfg[3][3:0])])
    else $error("stopped event not published");
  a_clk_rst: assert property ( // R16
    $rose(rst_n) |-> r_reg.clkctrl == pmc_pkg::CLKCTRL_RST)
    else $error("clock control reset wrong");

  c_start: cover property (r_reg.fsm == pmc_pkg::PMC_RUN);
  c_write: cover property (dma_we);
  c_swap:  cover property (ev_p[2] && ev_p[0]);
  c_stop:  cover property (r_reg.fsm == pmc_pkg::PMC_ACK);
endmodule // pmc_top
`default_nettype wire

// ### tb_pmc_top.sv
// Self-checking bench for the mic port top.
// Assumes a 200 MHz clock and two mics sharing one data line.
`timescale 1ns/1ps
`default_nettype none
module tb_pmc_top;
  logic        clk_sys = 1'b0;    // System clock
  logic        rst_n = 1'b0;      // Reset, active low
  logic [11:0] reg_addr = '0;     // Register offset
  logic [31:0] reg_wdata = '0;    // Write data
  logic        reg_we = 1'b0;     // Write strobe
  logic        reg_re = 1'b0;     // Read strobe
  logic [15:0] chan_in = '0;      // Channel pulses
  logic [31:0] reg_rdata, dma_addr, dma_wdata;
  logic [15:0] chan_out;
  logic [4:0]  clk_pin, din_pin_num;
  logic        irq, din_pin, mic_bit_clock, mic_clk_oe;
  logic        clk_route, din_route, dma_we;
  int          n_errors = 0, comparisons = 0, n_pub = 0;
  logic [31:0] rq[$];             // Expected read data
  logic [63:0] dq[$];             // Expected address and word
  logic        pend = 1'b0;       // Read answer due
  logic [31:0] p0, p1;            // Buffer pointers
  logic [31:0] words [4] = '{32'hC000_4000, 32'h4000_4000,
                             32'h5000_B000, 32'hC000_C000};
  pmc_top i_pmc_top (
    .clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .chan_in(chan_in), .chan_out(chan_out),
    .irq(irq), .din_pin(din_pin), .mic_bit_clock(mic_bit_clock),
    .mic_clk_oe(mic_clk_oe), .clk_route(clk_route), .clk_pin(clk_pin),
    .din_route(din_route), .din_pin_num(din_pin_num),
    .dma_addr(dma_addr), .dma_wdata(dma_wdata), .dma_we(dma_we)
  );
  pmc_mic_model i_pmc_mic_model (
    .clk_sys(clk_sys), .mic_clk(mic_bit_clock), .clk_on(mic_clk_oe),
    .din_on(din_route), .din(din_pin)
  );
  always #2.5 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge clk_sys);
    reg_we <= 1'b0;
  endtask
  // Read, noting the answer expected
  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    rq.push_back(e);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge clk_sys);
    reg_re <= 1'b0;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Bounded wait until n words remain due
  task automatic drain(input int n);
    for (int i = 0; i < 40000 && dq.size() > n; i++) @(posedge clk_sys);
    chk(32'(dq.size()), 32'(n));
  endtask
  // Output watcher, away from the sampling edge
  always @(negedge clk_sys) begin
    if (pend) chk(reg_rdata, rq.pop_front());
    pend = reg_re;
    if (dma_we) begin
      chk(dma_addr, dq[0][63:32]);
      chk(dma_wdata, dq[0][31:0]);
      void'(dq.pop_front());
    end
    if (chan_out[2]) n_pub++;
  end
  // Watchdog beyond the longest run
  initial begin
    #450_000;
    n_errors++;
    end_of_test();
  end
  initial begin
    void'($urandom(72));
    cyc(6);
    rst_n <= 1'b1;
    rd(12'h504, 32'h0840_0000);
    rd(12'h540, 32'hFFFF_FFFF);
    rd(12'h000, 32'h0000_0000);
    rd(12'h00C, 32'h0000_0000);
    wr(12'h504, 32'h0A80_0000);
    rd(12'h504, 32'h0A80_0000);
    wr(12'h304, 32'h0000_0005);
    rd(12'h300, 32'h0000_0005);
    wr(12'h308, 32'h0000_0001);
    rd(12'h304, 32'h0000_0004);
    wr(12'h300, 32'h0000_0007);
    rd(12'h308, 32'h0000_0007);
    wr(12'h540, 32'h0000_0003);
    wr(12'h544, 32'h0000_0004);
    cyc(2);
    chk(32'(clk_route), 32'h0000_0000);
    // pin selects set up before enable
    wr(12'h500, 32'h0000_0001);
    wr(12'h180, 32'h8000_0002);
    wr(12'h184, 32'h8000_0007);
    wr(12'h084, 32'h8000_0005);
    cyc(2);
    chk(32'({clk_route, din_route, clk_pin, din_pin_num}), 32'h0C64);
    for (int m = 0; m < 4; m++) begin
      p0 = $urandom() & 32'hFFFF_FFFC;
      p1 = p0 + 32'h0000_0100;
      wr(12'h508, 32'(m));
      wr(12'h520, 32'(m == 2)); // ratio 80 once
      wr(12'h560, p0);
      wr(12'h564, (m == 0) ? 32'h0000_0002 : 32'h0000_0008);
      dq.push_back({p0, words[m]});
      wr(12'h000, 32'h0000_0001);
      if (m == 0) begin
        wr(12'h560, p1);
        cyc(3);
        chk(32'(n_pub), 32'h0000_0001);
        dq.push_back({p1, words[0]});
        drain(1);
      end
      // Stop by register, or by subscribed channel
      if (m < 2) wr(12'h004, 32'h0000_0001);
      else begin
        @(posedge clk_sys);
        chan_in <= 16'h0020;
        @(posedge clk_sys);
        chan_in <= 16'h0000;
      end
      drain(0);
      cyc(3);
      rd(12'h104, 32'h0000_0001);
      rd(12'h108, 32'h0000_0001);
      rd(12'h100, 32'h0000_0001);
      chk(32'(irq), 32'h0000_0001);
      wr(12'h100, 32'h0000_0000);
      wr(12'h104, 32'h0000_0000);
      wr(12'h108, 32'h0000_0000);
      cyc(3);
      chk(32'(irq), 32'h0000_0000);
    end
    wr(12'h540, 32'h8000_0003);
    cyc(2);
    chk(32'(clk_route), 32'h0000_0000);
    wr(12'h500, 32'h0000_0000);
    cyc(2);
    chk(32'({din_route, mic_bit_clock}), 32'h0000_0000);
    end_of_test();
  end
endmodule // tb_pmc_top
`default_nettype wire
